// ===== hdl/rre_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "rre_params.svh"
module rre_exec import rre_pkg::*; #(
	parameter int PC_WIDTH = `RRE_PC_WIDTH
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// instruction issue
	input wire logic instrValid,
	input wire logic [13:0] instrWord,
	output logic busy,
	// operands from the core
	input wire logic [7:0] fileRdData,
	input wire logic carryIn,
	input wire logic [PC_WIDTH-1:0] topOfCallStack,
	// program counter and stack
	output logic stackPop,
	output logic pcLoad,
	output logic [PC_WIDTH-1:0] pcValue,
	// working register
	output logic wLoad,
	output logic [7:0] wValue,
	// file register write
	output logic fileWrEn,
	output logic [6:0] fileWrAddr,
	output logic [7:0] fileWrData,
	// status and interrupt control
	output logic carryLoad,
	output logic carryValue,
	output logic globalInterruptEnableSet
);
	// ==========================================
	// elaboration check
	if (PC_WIDTH < 8 || PC_WIDTH > 16) begin : g_bad_pc
		$error("PC_WIDTH must lie between 8 and 16");
	end

	// ==========================================
	// state
	typedef struct packed {
		logic busy;
		logic stackPop;
		logic pcLoad;
		logic [PC_WIDTH-1:0] pcValue;
		logic wLoad;
		logic [7:0] wValue;
		logic fileWrEn;
		logic [6:0] fileWrAddr;
		logic [7:0] fileWrData;
		logic carryLoad;
		logic carryValue;
		logic intEnSet;
	} rre_state_t;

	rre_state_t state_q;
	rre_state_t state_d;
	rre_op_t op;
	logic take;
	rre_rot_if rot ();

	rre_rotate u_rotate (
		.rot(rot)
	);

	// ==========================================
	// decode
	always_comb begin
		op = RRE_OP_NONE;
		if (instrWord == `RRE_OP_RETURN) begin
			op = RRE_OP_RET;
		end else if (instrWord == `RRE_OP_RETINT) begin
			op = RRE_OP_RETI;
		end else if ((instrWord[`RRE_HI4_TOP:`RRE_HI4_BOT] &
				`RRE_RETLIT_MASK_TOP) == (`RRE_RETLIT_HI &
				`RRE_RETLIT_MASK_TOP)) begin
			// lowest bit of the top nibble (bit 10) is don't-care
			op = RRE_OP_RETK;
		end else if (instrWord[`RRE_HI6_TOP:`RRE_HI6_BOT] ==
				`RRE_ROTL_HI) begin
			op = RRE_OP_ROT;
		end
	end

	// second return cycle is a pipeline flush, issue is refused
	assign take = instrValid && !state_q.busy;
	assign rot.operand = fileRdData;
	assign rot.carryIn = carryIn;

	// ==========================================
	// next state
	always_comb begin
		state_d = '0;
		state_d.fileWrAddr = state_q.fileWrAddr;
		state_d.pcValue = state_q.pcValue;
		state_d.wValue = state_q.wValue;
		state_d.fileWrData = state_q.fileWrData;
		state_d.carryValue = state_q.carryValue;
		if (take) begin
			unique case (op)
				RRE_OP_RET, RRE_OP_RETI, RRE_OP_RETK: begin
					state_d.busy = 1'b1;
					state_d.stackPop = 1'b1;
					state_d.pcLoad = 1'b1;
					state_d.pcValue = topOfCallStack;
					state_d.intEnSet = (op == RRE_OP_RETI);
					if (op == RRE_OP_RETK) begin
						state_d.wLoad = 1'b1;
						state_d.wValue = instrWord[`RRE_LIT_TOP:0];
					end
				end
				RRE_OP_ROT: begin
					// only carry of the status flags moves
					state_d.carryLoad = 1'b1;
					state_d.carryValue = rot.carryOut;
					if (instrWord[`RRE_DEST_BIT]) begin
						state_d.fileWrEn = 1'b1;
						state_d.fileWrAddr = instrWord[`RRE_ADDR_TOP:0];
						state_d.fileWrData = rot.result;
					end else begin
						state_d.wLoad = 1'b1;
						state_d.wValue = rot.result;
					end
				end
				RRE_OP_NONE: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================
	// outputs
	assign busy = state_q.busy;
	assign stackPop = state_q.stackPop;
	assign pcLoad = state_q.pcLoad;
	assign pcValue = state_q.pcValue;
	assign wLoad = state_q.wLoad;
	assign wValue = state_q.wValue;
	assign fileWrEn = state_q.fileWrEn;
	assign fileWrAddr = state_q.fileWrAddr;
	assign fileWrData = state_q.fileWrData;
	assign carryLoad = state_q.carryLoad;
	assign carryValue = state_q.carryValue;
	assign globalInterruptEnableSet = state_q.intEnSet;

	// ==========================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence retTaken;
		take && (op == RRE_OP_RET || op == RRE_OP_RETI ||
			op == RRE_OP_RETK);
	endsequence
	sequence flushThenFree;
		busy ##1 !busy;
	endsequence
	sequence pulsesQuiet;
		!stackPop && !pcLoad && !wLoad && !fileWrEn && !carryLoad &&
			!globalInterruptEnableSet;
	endsequence

	intret_pop_a: assert property (take && op == RRE_OP_RETI |=>
		stackPop && pcLoad && pcValue == $past(topOfCallStack))
		else $error("interrupt return did not pop the stack");
	int_enable_a: assert property (globalInterruptEnableSet |->
		$past(take) && $past(op) == RRE_OP_RETI && stackPop)
		else $error("interrupt enable set without interrupt return");
	ret_two_cycle_a: assert property (retTaken |=> flushThenFree)
		else $error("return did not take two cycles");
	litret_w_a: assert property (take && op == RRE_OP_RETK |=>
		wLoad && wValue == $past(instrWord[7:0]))
		else $error("literal return gave a wrong working value");
	litret_pc_a: assert property (take && op == RRE_OP_RETK |=>
		pcLoad && stackPop && pcValue == $past(topOfCallStack))
		else $error("literal return gave a wrong return address");
	return_only_a: assert property (take && op == RRE_OP_RET |=>
		pcLoad && !wLoad && !globalInterruptEnableSet)
		else $error("plain return changed more than the pc");
	rot_value_a: assert property (take && op == RRE_OP_ROT |=>
		carryValue == $past(fileRdData[7]) &&
		(wLoad ? wValue : fileWrData) ==
		{$past(fileRdData[6:0]), $past(carryIn)})
		else $error("rotate produced a wrong value");
	rot_dest_a: assert property (take && op == RRE_OP_ROT |=>
		(fileWrEn == $past(instrWord[7])) && (wLoad != fileWrEn) &&
		(!fileWrEn || fileWrAddr == $past(instrWord[6:0])))
		else $error("rotate wrote the wrong destination");
	rot_flags_a: assert property (carryLoad |-> !busy && !pcLoad
		##1 !carryLoad || $past(take))
		else $error("carry moved outside a one-cycle rotate");
	// an issue taken in the flush would pop the stack a second time
	flush_refuse_a: assert property (busy |=> pulsesQuiet)
		else $error("issue taken in a return flush cycle");
	ret_no_flag_a: assert property (retTaken |=>
		!carryLoad && !fileWrEn)
		else $error("return moved a status flag");
	rot_single_a: assert property (take && op == RRE_OP_ROT |=>
		!busy && !stackPop && !pcLoad)
		else $error("rotate took more than one cycle");
	idle_word_a: assert property (take && op == RRE_OP_NONE |=>
		pulsesQuiet)
		else $error("unknown word had an effect");
endmodule
`default_nettype wire

// ===== hdl/rre_params.svh
`ifndef RRE_PARAMS_SVH
`define RRE_PARAMS_SVH

// ==========================================
// instruction encodings (14-bit program word)
`define RRE_OP_RETURN 14'h0008
`define RRE_OP_RETINT 14'h0009
`define RRE_RETLIT_HI 4'hd
`define RRE_RETLIT_MASK 4'hf
`define RRE_RETLIT_MASK_TOP 4'he
`define RRE_ROTL_HI 6'h0d

// ==========================================
// field positions
`define RRE_HI4_TOP 13
`define RRE_HI4_BOT 10
`define RRE_HI6_TOP 13
`define RRE_HI6_BOT 8
`define RRE_DEST_BIT 7
`define RRE_ADDR_TOP 6
`define RRE_LIT_TOP 7
`define RRE_INTEN_BIT 7
`define RRE_MSB_BIT 7

// ==========================================
// timing, width and reset values
`define RRE_RET_CYCLES 2
`define RRE_ROT_CYCLES 1
`define RRE_PC_WIDTH 13
`define RRE_ZERO8 8'h00

`endif

// ===== hdl/rre_pkg.sv
package rre_pkg;
	typedef enum logic [2:0] {
		RRE_OP_NONE = 3'b000,
		RRE_OP_RET = 3'b001,
		RRE_OP_RETI = 3'b010,
		RRE_OP_RETK = 3'b011,
		RRE_OP_ROT = 3'b100
	} rre_op_t;
endpackage

// ===== hdl/rre_rot_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rre_rot_if;
	logic [7:0] operand;
	logic carryIn;
	logic [7:0] result;
	logic carryOut;
	modport exec (output operand, output carryIn, input result,
		input carryOut);
	modport unit (input operand, input carryIn, output result,
		output carryOut);
endinterface
`default_nettype wire

// ===== hdl/rre_rotate.sv
`timescale 1ns/1ps
`default_nettype none
`include "rre_params.svh"
module rre_rotate (
	rre_rot_if.unit rot
);
	// ==========================================
	// rotate left through carry
	always_comb begin
		rot.result = {rot.operand[6:0], rot.carryIn};
		rot.carryOut = rot.operand[`RRE_MSB_BIT];
	end
endmodule
`default_nettype wire

// ===== verif/return_and_rotate_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rre_params.svh"
module return_and_rotate_exec_test import rre_pkg::*;;
	// ==========================================
	// stimulus and design
	logic sys_clk = 1'b0, rst_n = 1'b0, instrValid = 1'b0, carryIn = 1'b0;
	logic [13:0] instrWord = 14'h0000;
	logic [7:0] fileRdData = 8'h00;
	logic [12:0] topOfCallStack = 13'h0000;
	logic busy, stackPop, pcLoad, wLoad, fileWrEn, carryLoad, carryValue;
	logic globalInterruptEnableSet;
	logic [12:0] pcValue;
	logic [7:0] wValue, fileWrData;
	logic [6:0] fileWrAddr;
	int bad_count = 0, checks_done = 0, seed = 27, i;
	logic [31:0] rnd;
	logic [13:0] word;
	rre_exec u_rre_exec (.sys_clk(sys_clk), .rst_n(rst_n),
		.instrValid(instrValid), .instrWord(instrWord), .busy(busy),
		.fileRdData(fileRdData), .carryIn(carryIn),
		.topOfCallStack(topOfCallStack), .stackPop(stackPop),
		.pcLoad(pcLoad), .pcValue(pcValue), .wLoad(wLoad), .wValue(wValue),
		.fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
		.fileWrData(fileWrData), .carryLoad(carryLoad),
		.carryValue(carryValue),
		.globalInterruptEnableSet(globalInterruptEnableSet));
	initial forever #25 sys_clk = ~sys_clk;
	// ==========================================
	// checking helpers
	task automatic close_out;
		$display("mismatches %0d, checks %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic ok, input string what);
		checks_done++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	function automatic rre_op_t kindOf(input logic [13:0] w);
		if (w == `RRE_OP_RETURN) return RRE_OP_RET;
		if (w == `RRE_OP_RETINT) return RRE_OP_RETI;
		if (w[13:11] == 3'h6) return RRE_OP_RETK;
		if (w[13:8] == `RRE_ROTL_HI) return RRE_OP_ROT;
		return RRE_OP_NONE;
	endfunction
	function automatic logic [7:0] rotExp(input logic [7:0] f,
		input logic c);
		return {f[6:0], c};
	endfunction
	function automatic logic idle();
		return {busy, stackPop, pcLoad, wLoad, fileWrEn, carryLoad,
			globalInterruptEnableSet} === 7'h00;
	endfunction
	// ==========================================
	// one instruction, with a refused issue in a return's flush cycle
	task automatic run(input logic [13:0] w, input logic [7:0] f,
		input logic c, input logic [12:0] top_of_call_stack);
		rre_op_t k;
		logic ret, rot, wl, fd;
		logic [7:0] r;
		k = kindOf(w);
		ret = k inside {RRE_OP_RET, RRE_OP_RETI, RRE_OP_RETK};
		rot = (k == RRE_OP_ROT);
		r = rotExp(f, c);
		fd = rot && w[7];
		wl = (k == RRE_OP_RETK) || (rot && !w[7]);
		@(posedge sys_clk);
		instrValid <= 1'b1;
		instrWord <= w;
		fileRdData <= f;
		carryIn <= c;
		topOfCallStack <= top_of_call_stack;
		@(posedge sys_clk);
		// a return's flush cycle must swallow this interrupt return
		instrValid <= ret;
		instrWord <= `RRE_OP_RETINT;
		fileRdData <= ~f;
		carryIn <= ~c;
		topOfCallStack <= ~top_of_call_stack;
		#1;
		chk(busy === ret, "busy");
		chk(stackPop === ret && pcLoad === ret, "pop");
		if (ret) chk(pcValue === top_of_call_stack, "pc value");
		chk(globalInterruptEnableSet === (k == RRE_OP_RETI), "int en");
		chk(wLoad === wl, "w load");
		if (wl) chk(wValue === (rot ? r : w[7:0]), "w value");
		chk(fileWrEn === fd, "file write");
		if (fd) chk(fileWrAddr === w[6:0], "file addr");
		if (fd) chk(fileWrData === r, "file data");
		chk(carryLoad === rot, "carry load");
		if (rot) chk(carryValue === f[7], "carry value");
		@(posedge sys_clk);
		instrValid <= 1'b0;
		#1;
		chk(idle(), "second cycle");
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk(idle(), "reset");
		run(`RRE_OP_RETURN, 8'h5a, 1'b1, 13'h1fff);
		run(`RRE_OP_RETINT, 8'h00, 1'b0, 13'h0000);
		run(14'h3400, 8'h11, 1'b1, 13'h0abc);
		run(14'h37ff, 8'h22, 1'b0, 13'h1555);
		run(14'h0d11, 8'he6, 1'b0, 13'h0001);
		run(14'h0dff, 8'h7f, 1'b1, 13'h0002);
		run(14'h0000, 8'hff, 1'b1, 13'h0003); // unknown word, no effect
		run(14'h000a, 8'h80, 1'b0, 13'h0004);
		// random mix of every kind plus arbitrary words
		for (i = 0; i < 300; i++) begin
			rnd = $random(seed);
			case (rnd[31:29] % 5)
				0: word = `RRE_OP_RETURN;
				1: word = `RRE_OP_RETINT;
				2: word = {3'h6, rnd[10:0]};
				3: word = {`RRE_ROTL_HI, rnd[7:0]};
				default: word = rnd[13:0];
			endcase
			run(word, rnd[19:12], rnd[20], rnd[28:16]);
		end
		close_out();
	end
	// cut a hang short well past the expected ~1000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire
